// [include/bcs_cfg.svh]
`ifndef BCS_CFG_SVH
`define BCS_CFG_SVH
`define BCS_WORD_W      48
`define BCS_GROUPS      4
`define BCS_CHANS       7
`define BCS_XFER_IDX    3'h6
`define BCS_LAST_SLOT   3'h5
`define BCS_CLK_NS      50
`define BCS_ROUND_NS    3200
`define BCS_ROUND_CYC   (`BCS_ROUND_NS / `BCS_CLK_NS)
`define BCS_SLOT_CYC    ((`BCS_ROUND_NS / `BCS_CLK_NS) / 6)
`define BCS_WORST_NS    200000
`define BCS_WORST_CYC   (`BCS_WORST_NS / `BCS_CLK_NS)
`define BCS_SETTLE_NS   100
`define BCS_SETTLE_CYC  ((`BCS_SETTLE_NS + `BCS_CLK_NS - 1) / `BCS_CLK_NS)
`define BCS_FIFO_DEPTH  32
`endif

// [include/bcs_pkg.sv]
`default_nettype none
`include "bcs_cfg.svh"
package bcs_pkg;
    typedef enum logic [3:0]
    {
        ST_SCAN       = 4'h1,
        ST_IN_TAKE    = 4'h2,
        ST_OUT_FETCH  = 4'h4,
        ST_OUT_SETTLE = 4'h8
    } bcs_state_type;

    typedef struct packed {
        bcs_state_type                   st;
        logic [2:0]                      slot;
        logic [3:0]                      dwell;
        logic [2:0]                      cur;
        logic [6:0]                      act;
        logic [6:0][15:0]                cnt;
        logic                            xdir;
        logic [3:0]                      ires;
        logic [3:0]                      ordy;
        logic [3:0][`BCS_WORD_W-1:0]     oreg;
        logic [`BCS_WORD_W-1:0]          xreg;
        logic [2:0]                      xtag;
        logic                            wr_valid;
        logic [3:0]                      rdy1;
        logic [3:0]                      rdy2;
        logic [3:0]                      ores1;
        logic [3:0]                      ores2;
        logic [3:0][`BCS_WORD_W-1:0]     din1;
        logic [3:0][`BCS_WORD_W-1:0]     din2;
        logic [3:0]                      irq1;
        logic [3:0]                      irq2;
        logic                            irq_seen;
        logic                            adv_pend;
        logic                            irq_go;
        logic                            adv_go;
        logic                            word_req;
        logic [1:0]                      settle;
        logic [12:0]                     wait_cnt;
    } bcs_regs_type;
endpackage : bcs_pkg
`default_nettype wire

// [hdl/bcs_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module bcs_fifo #(
    parameter int W = 51,
    parameter int D = 32
) (
    // Clock and reset.
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    // Write side.
    input  wire logic         wr_valid_in,
    output logic              wr_ready_out,
    input  wire logic [W-1:0] wr_data_in,
    // Read side.
    output logic              rd_valid_out,
    input  wire logic         rd_ready_in,
    output logic [W-1:0]      rd_data_out
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   n;
        logic          full;
        logic          empty;
    } bcs_fifo_type;

    bcs_fifo_type q;
    bcs_fifo_type d;
    logic [W-1:0] mem [D];
    logic         push;
    logic         pop;

    assign push         = wr_valid_in && !q.full;
    assign pop          = rd_ready_in && !q.empty;
    assign wr_ready_out = !q.full;
    assign rd_valid_out = !q.empty;
    assign rd_data_out  = mem[q.rp];

    always_comb
    begin
        d = q;
        if (push)
        begin
            d.wp = q.wp + AW'(1);
        end
        if (pop)
        begin
            d.rp = q.rp + AW'(1);
        end
        d.n     = q.n + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        d.full  = (d.n == (AW + 1)'(D));
        d.empty = (d.n == '0);
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            q <= '{wp: '0, rp: '0, n: '0, full: 1'b0, empty: 1'b1};
        end
        else
        begin
            q <= d;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            mem[q.wp] <= wr_data_in;
        end
    end
endmodule : bcs_fifo
`default_nettype wire

// [hdl/bcs_scanner.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bcs_cfg.svh"
module bcs_scanner
    import bcs_pkg::*;
(
    // Clock and reset.
    input  wire logic                               clk_in,
    input  wire logic                               rst_n_in,
    // Block activation; channel 0..5 buffer, 6 transfer.
    input  wire logic                               start_in,
    input  wire logic [2:0]                         start_chan_in,
    input  wire logic                               start_dir_in,
    input  wire logic [15:0]                        start_len_in,
    // Cable group input side.
    input  wire logic [3:0]                         in_rdy_in,
    output logic [3:0]                              in_res_out,
    input  wire logic [3:0][`BCS_WORD_W-1:0]        in_data_in,
    output logic [3:0]                              in_act_out,
    // Cable group output side.
    output logic [3:0]                              out_rdy_out,
    input  wire logic [3:0]                         out_res_in,
    output logic [3:0][`BCS_WORD_W-1:0]             out_data_out,
    output logic [3:0]                              out_act_out,
    // Interrupt and clock-advance routines.
    input  wire logic [3:0]                         irq_line_in,
    input  wire logic                               clk_adv_req_in,
    output logic                                    irq_start_out,
    output logic                                    clk_adv_start_out,
    // Storage side: output words fetched on request.
    output logic                                    word_req_out,
    output logic [2:0]                              word_chan_out,
    input  wire logic [`BCS_WORD_W-1:0]             word_data_in,
    input  wire logic                               word_valid_in,
    // Storage side: received words.
    output logic [`BCS_WORD_W-1:0]                  rx_data_out,
    output logic [2:0]                              rx_chan_out,
    output logic                                    rx_valid_out,
    input  wire logic                               rx_ready_in
);
    localparam logic [3:0] SLOT_LAST = 4'(`BCS_SLOT_CYC - 1);
    localparam logic [1:0] SETTLE_LD = 2'(`BCS_SETTLE_CYC - 1);
    // The first slots of a round run one cycle longer so that a round spans 3.2 us.
    localparam logic [2:0] LONG_SLOTS = 3'(`BCS_ROUND_CYC % 6);

    bcs_regs_type q;
    bcs_regs_type d;
    logic         wr_ready;
    logic [2:0]   cand;
    logic [1:0]   cgrp;
    logic         cin;
    logic         svc_in;
    logic         svc_out;
    logic         x_in;
    logic         x_need;
    logic [1:0]   grp;
    logic [2:0]   oidx;
    logic [3:0]   dwell_end;

    bcs_fifo #(
        .W (`BCS_WORD_W + 3),
        .D (`BCS_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .wr_valid_in  (q.wr_valid),
        .wr_ready_out (wr_ready),
        .wr_data_in   ({q.xtag, q.xreg}),
        .rd_valid_out (rx_valid_out),
        .rd_ready_in  (rx_ready_in),
        .rd_data_out  ({rx_chan_out, rx_data_out})
    );

    // Even channel numbers (slots 0, 2, 4) are inputs; transfer is group four.
    function automatic logic [1:0] grp_of(input logic [2:0] c);
        grp_of = (c == `BCS_XFER_IDX) ? 2'h3 : c[2:1];
    endfunction : grp_of

    assign in_res_out        = q.ires;
    assign out_rdy_out       = q.ordy;
    assign out_data_out      = q.oreg;
    assign in_act_out        = {1'b0, q.act[4], q.act[2], q.act[0]};
    assign out_act_out       = {1'b0, q.act[5], q.act[3], q.act[1]};
    assign irq_start_out     = q.irq_go;
    assign clk_adv_start_out = q.adv_go;
    assign word_req_out      = q.word_req;
    assign word_chan_out     = q.cur;

    always_comb
    begin
        grp    = 2'h0;
        oidx   = 3'h0;
        dwell_end = (q.slot < LONG_SLOTS) ? SLOT_LAST + 4'h1 : SLOT_LAST;
        d      = q;
        d.rdy1 = in_rdy_in;
        d.rdy2 = q.rdy1;
        d.ores1 = out_res_in;
        d.ores2 = q.ores1;
        d.din1 = in_data_in;
        d.din2 = q.din1;
        d.irq1 = irq_line_in;
        d.irq2 = q.irq1;
        d.irq_go = 1'b0;
        d.adv_go = 1'b0;

        // The transfer channel is checked first at each slot, ahead of the sweep.
        x_in   = q.xdir;
        x_need = q.act[6] && q.cnt[6] != 16'h0000 && (x_in
                 ? (q.rdy2[3] && !q.ires[3] && !q.wr_valid && wr_ready)
                 : (!q.ordy[3] && !q.ores2[3]));
        cand   = x_need ? `BCS_XFER_IDX : q.slot;
        cgrp   = grp_of(cand);
        cin    = x_need ? x_in : !cand[0];
        svc_in  = q.act[cand] && cin && q.rdy2[cgrp] && !q.ires[cgrp]
                  && !q.wr_valid && wr_ready;
        svc_out = q.act[cand] && !cin && !q.ordy[cgrp] && !q.ores2[cgrp];

        if (q.wr_valid && wr_ready)
        begin
            d.wr_valid = 1'b0;
        end

        for (int g = 0; g < 4; g++)
        begin
            grp  = 2'(g);
            oidx = (grp == 2'h3) ? `BCS_XFER_IDX : {grp, 1'b1};
            if (q.ires[g] && !q.rdy2[g])
            begin
                d.ires[g] = 1'b0;
            end
            if (q.ordy[g] && q.ores2[g])
            begin
                d.ordy[g] = 1'b0;
                d.cnt[oidx] = q.cnt[oidx] - 16'h0001;
                if (q.cnt[oidx] == 16'h0001)
                begin
                    d.act[oidx] = 1'b0;
                end
            end
        end

        if (q.irq2 == 4'h0)
        begin
            d.irq_seen = 1'b0;
        end

        case (q.st)
            ST_SCAN:
            begin
                if (q.dwell == 4'h0)
                begin
                    if (q.irq2 != 4'h0 && !q.irq_seen)
                    begin
                        d.irq_go   = 1'b1;
                        d.irq_seen = 1'b1;
                    end
                    if (q.adv_pend)
                    begin
                        d.adv_go   = 1'b1;
                        d.adv_pend = 1'b0;
                    end
                end
                if (q.dwell == 4'h0 && (svc_in || svc_out))
                begin
                    d.cur = cand;
                    d.st  = svc_in ? ST_IN_TAKE : ST_OUT_FETCH;
                    d.word_req = svc_out;
                end
                else if (q.dwell == dwell_end)
                begin
                    d.dwell = 4'h0;
                    d.slot  = (q.slot == `BCS_LAST_SLOT) ? 3'h0 : q.slot + 3'h1;
                end
                else
                begin
                    d.dwell = q.dwell + 4'h1;
                end
            end
            ST_IN_TAKE:
            begin
                grp         = grp_of(q.cur);
                d.xreg      = q.din2[grp];
                d.xtag      = q.cur;
                d.wr_valid  = 1'b1;
                d.ires[grp] = 1'b1;
                d.cnt[q.cur] = q.cnt[q.cur] - 16'h0001;
                if (q.cnt[q.cur] == 16'h0001)
                begin
                    d.act[q.cur] = 1'b0;
                end
                d.st = ST_SCAN;
                if (q.cur != `BCS_XFER_IDX)
                begin
                    d.slot = (q.slot == `BCS_LAST_SLOT) ? 3'h0 : q.slot + 3'h1;
                end
                d.dwell = 4'h0;
            end
            ST_OUT_FETCH:
            begin
                if (word_valid_in)
                begin
                    d.oreg[grp_of(q.cur)] = word_data_in;
                    d.word_req = 1'b0;
                    d.settle   = SETTLE_LD;
                    d.st       = ST_OUT_SETTLE;
                end
            end
            ST_OUT_SETTLE:
            begin
                if (q.settle == 2'h0)
                begin
                    d.ordy[grp_of(q.cur)] = 1'b1;
                    d.st = ST_SCAN;
                    if (q.cur != `BCS_XFER_IDX)
                    begin
                        d.slot = (q.slot == `BCS_LAST_SLOT) ? 3'h0 : q.slot + 3'h1;
                    end
                    d.dwell = 4'h0;
                end
                else
                begin
                    d.settle = q.settle - 2'h1;
                end
            end
            default:
            begin
                d.st = ST_SCAN;
            end
        endcase

        if (clk_adv_req_in)
        begin
            d.adv_pend = 1'b1;
        end

        if (start_in && start_chan_in <= `BCS_XFER_IDX)
        begin
            d.act[start_chan_in] = (start_len_in != 16'h0000);
            d.cnt[start_chan_in] = start_len_in;
            if (start_chan_in == `BCS_XFER_IDX)
            begin
                d.xdir = start_dir_in;
            end
        end

        if (q.act[0] && q.rdy2[0] && !q.ires[0] && wr_ready)
        begin
            d.wait_cnt = q.wait_cnt + 13'h0001;
        end
        else
        begin
            d.wait_cnt = 13'h0000;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            q    <= '0;
            q.st <= ST_SCAN;
        end
        else
        begin
            q <= d;
        end
    end

    sequence s_take_in;
        q.st == ST_IN_TAKE ##1 q.st == ST_SCAN;
    endsequence

    a_slot_wrap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        q.st == ST_SCAN && q.slot == `BCS_LAST_SLOT && q.dwell == SLOT_LAST
        |=> q.slot == 3'h0)
        else $error("scanner did not wrap to first channel");

    a_slot_dwell: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        q.st == ST_SCAN && q.dwell == 4'h1 |-> ##8 q.dwell == SLOT_LAST || q.st != ST_SCAN)
        else $error("slot dwell length wrong");

    a_slot_long: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        q.st == ST_SCAN && q.dwell == SLOT_LAST && q.slot < LONG_SLOTS
        |=> q.dwell == SLOT_LAST + 4'h1)
        else $error("long slot ended early");

    a_take_resume: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        q.st == ST_IN_TAKE && q.cur != `BCS_XFER_IDX
        |-> s_take_in ##0 (q.ires[grp_of($past(q.cur))] && q.wr_valid))
        else $error("input word take did not resume and push");

    a_resume_drop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        q.ires[0] && !q.rdy2[0] |=> !q.ires[0])
        else $error("input resume held after ready removed");

    a_ready_settle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(q.ordy[1]) |-> $past(q.st) == ST_OUT_SETTLE && $past(q.settle) == 2'h0)
        else $error("output ready raised before lines settled");

    a_ready_drop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        q.ordy[0] && q.ores2[0] |=> !q.ordy[0])
        else $error("output ready held after resume");

    a_in_active: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $fell(in_act_out[0]) && !$past(start_in) |-> q.ires[0])
        else $error("input block active dropped without resume");

    a_xfer_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !in_act_out[3] && !out_act_out[3])
        else $error("transfer group block active driven");

    a_irq_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        q.st == ST_SCAN && q.dwell == 4'h0 && q.irq2 != 4'h0 && !q.irq_seen
        |=> irq_start_out ##1 !irq_start_out)
        else $error("interrupt routine not started");

    a_wait_bound: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        q.wait_cnt < 13'(`BCS_WORST_CYC))
        else $error("channel waited beyond worst case");
endmodule : bcs_scanner
`default_nettype wire

// [bench/bcs_equip_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bcs_cfg.svh"
module bcs_equip_model (
    // Clock, reset and pace.
    input  wire logic                        clk_in,
    input  wire logic                        rst_n_in,
    input  wire logic                        slow_in,
    // Input side of each cable group.
    output logic [3:0]                       in_rdy_out,
    input  wire logic [3:0]                  in_res_in,
    output logic [3:0][`BCS_WORD_W-1:0]      in_data_out,
    // Output side of each cable group.
    input  wire logic [3:0]                  out_rdy_in,
    output logic [3:0]                       out_res_out,
    input  wire logic [3:0][`BCS_WORD_W-1:0] out_data_in,
    // Observation.
    output logic [3:0][15:0]                 got_cnt_out,
    output logic [3:0][`BCS_WORD_W-1:0]      got_word_out,
    output logic                             err_out
);
    logic [3:0][43:0]             seq_q;
    logic [3:0][3:0]              dly_q;
    logic [3:0]                   prdy_q;
    logic [3:0]                   pres_q;
    logic [3:0][`BCS_WORD_W-1:0]  pdat_q;

    // Released data lines show the inverted word so a stale value never passes.
    always_comb
    begin
        for (int g = 0; g < 4; g++)
            in_data_out[g] = in_rdy_out[g] ? {4'(g), seq_q[g]} : ~{4'(g), seq_q[g]};
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            in_rdy_out   <= '0;
            out_res_out  <= '0;
            seq_q        <= '0;
            dly_q        <= '0;
            prdy_q       <= '0;
            pres_q       <= '0;
            pdat_q       <= '0;
            got_cnt_out  <= '0;
            got_word_out <= '0;
            err_out      <= 1'b0;
        end
        else
        begin
            prdy_q <= out_rdy_in;
            pres_q <= in_res_in;
            pdat_q <= out_data_in;
            for (int g = 0; g < 4; g++)
            begin
                if (in_rdy_out[g] && in_res_in[g])
                begin
                    in_rdy_out[g] <= 1'b0;
                    seq_q[g]      <= seq_q[g] + 44'h1;
                end
                else if (!in_rdy_out[g] && !in_res_in[g])
                    in_rdy_out[g] <= 1'b1;
                if (out_rdy_in[g] && !out_res_out[g])
                begin
                    if (dly_q[g] == (slow_in ? 4'h7 : 4'h0))
                    begin
                        out_res_out[g]  <= 1'b1;
                        got_word_out[g] <= out_data_in[g];
                        got_cnt_out[g]  <= got_cnt_out[g] + 16'h1;
                        dly_q[g]        <= 4'h0;
                    end
                    else
                        dly_q[g] <= dly_q[g] + 4'h1;
                end
                else if (!out_rdy_in[g])
                    out_res_out[g] <= 1'b0;
                if (out_rdy_in[g] && prdy_q[g] && (out_data_in[g] !== pdat_q[g]))
                    err_out <= 1'b1;
                // A resume that rises while no word is offered was never accepted.
                if (in_res_in[g] && !pres_q[g] && !in_rdy_out[g])
                    err_out <= 1'b1;
            end
        end
    end
endmodule : bcs_equip_model
`default_nettype wire

// [bench/buffer_channel_scanner_handshake_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bcs_cfg.svh"
module buffer_channel_scanner_handshake_tb;
    logic clk_in = 1'b0, rst_n_in = 1'b0, start_in = 1'b0, start_dir_in = 1'b0;
    logic [2:0] start_chan_in = 3'h0;
    logic [15:0] start_len_in = 16'h0;
    logic [3:0] irq_line_in = 4'h0, in_rdy, in_res, in_act, out_rdy, out_res, out_act;
    logic clk_adv_req_in = 1'b0, word_valid_in = 1'b0, rx_ready_in = 1'b0, slow = 1'b0;
    logic [`BCS_WORD_W-1:0] word_data_in = '0, rx_data;
    logic [44:0] ocnt = 45'h0;
    logic [3:0][`BCS_WORD_W-1:0] in_data, out_data, got_word;
    logic [3:0][15:0] got_cnt;
    logic [3:0][43:0] exp_seq = '0;
    logic [15:0] xgot;
    logic irq_go, adv_go, word_req, rx_valid, err;
    logic [2:0] word_chan, rx_chan;
    int error_cnt = 0, n_tests = 0, used;

    always #25 clk_in = ~clk_in;

    bcs_scanner uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(start_in),
        .start_chan_in(start_chan_in), .start_dir_in(start_dir_in), .start_len_in(start_len_in),
        .in_rdy_in(in_rdy), .in_res_out(in_res), .in_data_in(in_data), .in_act_out(in_act),
        .out_rdy_out(out_rdy), .out_res_in(out_res), .out_data_out(out_data),
        .out_act_out(out_act), .irq_line_in(irq_line_in), .clk_adv_req_in(clk_adv_req_in),
        .irq_start_out(irq_go), .clk_adv_start_out(adv_go), .word_req_out(word_req),
        .word_chan_out(word_chan), .word_data_in(word_data_in), .word_valid_in(word_valid_in),
        .rx_data_out(rx_data), .rx_chan_out(rx_chan), .rx_valid_out(rx_valid),
        .rx_ready_in(rx_ready_in));

    bcs_equip_model equip (.clk_in(clk_in), .rst_n_in(rst_n_in), .slow_in(slow),
        .in_rdy_out(in_rdy), .in_res_in(in_res), .in_data_out(in_data), .out_rdy_in(out_rdy),
        .out_res_out(out_res), .out_data_in(out_data), .got_cnt_out(got_cnt),
        .got_word_out(got_word), .err_out(err));

    // Storage answers every word request with its channel and a running count.
    always @(posedge clk_in)
    begin
        word_valid_in <= word_req;
        word_data_in  <= {word_chan, ocnt};
        if (word_valid_in && word_req)
            ocnt <= ocnt + 45'h1;
    end

    task automatic tally_and_finish();
        if (error_cnt == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        n_tests++;
        if (exp !== got)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask : chk

    function automatic logic cond(input int kind);
        case (kind)
            0: return (in_act === 4'h0) && (out_act === 4'h0);
            1: return irq_go === 1'b1;
            2: return adv_go === 1'b1;
            default: return got_cnt[3] !== xgot;
        endcase
    endfunction : cond

    task automatic wait_for(input int kind, input int max);
        used = 0;
        while (!cond(kind))
        begin
            @(posedge clk_in);
            #1;
            used++;
            if (used > max)
            begin
                $display("ERROR wait %0d expected done seen timeout", kind);
                error_cnt++;
                tally_and_finish();
            end
        end
    endtask : wait_for

    task automatic start_blk(input logic [2:0] ch, input logic dir, input logic [15:0] len);
        @(posedge clk_in);
        start_in      <= 1'b1;
        start_chan_in <= ch;
        start_dir_in  <= dir;
        start_len_in  <= len;
        @(posedge clk_in);
        start_in <= 1'b0;
        @(posedge clk_in);
        #1;
        if (ch < 3'h6)
            chk("act", 64'h1, 64'(ch[0] ? out_act[ch[2:1]] : in_act[ch[2:1]]));
        else
            chk("xfer_act", 64'h0, 64'({in_act[3], out_act[3]}));
    endtask : start_blk

    task automatic drain(input int n);
        int got;
        int spin;
        logic [1:0] g;
        got = 0;
        spin = 0;
        @(posedge clk_in);
        rx_ready_in <= 1'b1;
        while (got < n)
        begin
            @(negedge clk_in);
            spin++;
            if (spin > 5000)
            begin
                $display("ERROR drain expected %0d seen %0d", n, got);
                error_cnt++;
                tally_and_finish();
            end
            if (rx_valid === 1'b1)
            begin
                g = (rx_chan == 3'h6) ? 2'h3 : rx_chan[2:1];
                chk("rx_chan_in", 64'h0, 64'(rx_chan[0]));
                chk("rx_data", 64'({2'h0, g, exp_seq[g]}), 64'(rx_data));
                exp_seq[g] = exp_seq[g] + 44'h1;
                got++;
            end
        end
        @(posedge clk_in);
        rx_ready_in <= 1'b0;
        #1;
    endtask : drain

    task automatic s_routines();
        @(posedge clk_in);
        irq_line_in <= 4'h4;
        #1;
        wait_for(1, 200);
        @(posedge clk_in);
        irq_line_in    <= 4'h0;
        clk_adv_req_in <= 1'b1;
        #1;
        chk("irq_pulse", 64'h0, 64'(irq_go));
        @(posedge clk_in);
        clk_adv_req_in <= 1'b0;
        #1;
        wait_for(2, 200);
    endtask : s_routines

    task automatic s_fill_drain();
        start_blk(3'h0, 1'b1, 16'd33);
        repeat (2400) @(posedge clk_in);
        #1;
        chk("in_act_full", 64'h1, 64'(in_act[0]));
        chk("rx_valid_full", 64'h1, 64'(rx_valid));
        drain(33);
        wait_for(0, 200);
        repeat (3) @(posedge clk_in);
        #1;
        chk("rx_empty", 64'h0, 64'(rx_valid));
        chk("in_res_idle", 64'h0, 64'(in_res));
    endtask : s_fill_drain

    task automatic s_output();
        logic [15:0] base;
        slow <= 1'b1;
        base = got_cnt[1];
        start_blk(3'h3, 1'b0, 16'd2);
        wait_for(0, 1000);
        repeat (4) @(posedge clk_in);
        #1;
        chk("out_words", 64'(base + 16'h2), 64'(got_cnt[1]));
        chk("out_word", 64'({3'h3, ocnt - 45'h1}), 64'(got_word[1]));
        chk("out_rdy_idle", 64'h0, 64'(out_rdy));
        chk("out_stable", 64'h0, 64'(err));
        slow <= 1'b0;
    endtask : s_output

    task automatic s_all_six();
        for (int c = 0; c < 6; c++)
            start_blk(3'(c), 1'b1, 16'd1);
        wait_for(0, `BCS_WORST_CYC);
        drain(3);
        for (int g = 0; g < 3; g++)
            chk("out_grp", 64'(2 * g + 1), 64'(got_word[g][47:45]));
    endtask : s_all_six

    task automatic s_xfer();
        start_blk(3'h6, 1'b1, 16'd2);
        drain(2);
        xgot = got_cnt[3];
        start_blk(3'h6, 1'b0, 16'd1);
        wait_for(3, 500);
        chk("xfer_out", 64'h6, 64'(got_word[3][47:45]));
        chk("xfer_act_end", 64'h0, 64'({in_act[3], out_act[3]}));
        chk("equip_err", 64'h0, 64'(err));
    endtask : s_xfer

    initial
    begin
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        s_routines();
        s_fill_drain();
        s_output();
        s_all_six();
        s_xfer();
        tally_and_finish();
    end
endmodule : buffer_channel_scanner_handshake_tb
`default_nettype wire
